//--- shared/uvf_pkg.sv
`default_nettype none

package uvf_pkg;

  // ****************************************************************
  // Register command codes
  // ****************************************************************
  localparam logic [7:0] UVF_WARN_THRESHOLD_CMD = 8'h58;
  localparam logic [7:0] UVF_FAULT_THRESHOLD_CMD = 8'h59;
  localparam logic [7:0] UVF_FAULT_ACTION_CMD = 8'h5A;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int UVF_EXP_MSB = 15;
  localparam int UVF_EXP_LSB = 11;
  localparam int UVF_MANT_MSB = 10;
  localparam int UVF_MANT_LSB = 0;
  localparam int UVF_ACT_RESP_MSB = 7;
  localparam int UVF_ACT_RESP_LSB = 6;
  localparam int UVF_ACT_RETRY_MSB = 5;
  localparam int UVF_ACT_RETRY_LSB = 3;
  localparam int UVF_ACT_DELAY_MSB = 2;
  localparam int UVF_ACT_DELAY_LSB = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [10:0] UVF_WARN_MANT_RST = 11'h000;
  localparam logic [10:0] UVF_FAULT_MANT_RST = 11'h000;
  localparam logic [7:0] UVF_ACTION_RST = 8'h00;

  // ****************************************************************
  // Response codes and retry coding
  // ****************************************************************
  localparam logic [1:0] UVF_RESP_IGNORE = 2'h0;
  localparam logic [1:0] UVF_RESP_DELAYED = 2'h1;
  localparam logic [1:0] UVF_RESP_RETRY = 2'h2;
  localparam logic [1:0] UVF_RESP_HOLD = 2'h3;
  localparam logic [2:0] UVF_RETRY_FOREVER = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int UVF_CLK_KHZ = 250000;
  localparam int UVF_DELAY1_BASE_MS = 10;
  localparam logic [11:0] UVF_DELAY2_MS [8] = '{
    12'd252, 12'd558, 12'd924, 12'd1260,
    12'd1596, 12'd1932, 12'd2268, 12'd2604
  };

  typedef enum logic [4:0] {
    UVF_RUN = 5'b00001,
    UVF_DELAY = 5'b00010,
    UVF_OFF_WAIT = 5'b00100,
    UVF_HOLD = 5'b01000,
    UVF_LATCHED = 5'b10000
  } uvf_state_t;

endpackage : uvf_pkg

`default_nettype wire

//--- shared/uvf_tmr_if.sv
`default_nettype none

interface uvf_tmr_if;
  logic start;
  logic [11:0] ms;
  logic done;
  modport ctl (output start, output ms, input done);
  modport tmr (input start, input ms, output done);
endinterface : uvf_tmr_if

`default_nettype wire

//--- test/tb_uvf_handler.sv
`default_nettype none

module tb_uvf_handler
  import uvf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  // Four cycles per millisecond keeps the 252 ms wait near 1000 cycles.
  localparam int TICK = 4;
  logic core_clk;
  logic rst;
  logic [7:0] reg_cmd;
  logic reg_wr_en;
  logic [15:0] reg_wdata;
  logic reg_rd_en;
  logic [15:0] reg_rdata;
  logic [10:0] input_voltage;
  logic [2:0] exponent_code;
  logic bias_ok;
  logic output_enable;
  logic input_low_warning;
  logic input_low_fault;
  logic fault_latched;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  uvf_handler #(.TICK_CYCLES(TICK)) u_dut (
    .core_clk(core_clk), .rst(rst), .reg_cmd(reg_cmd),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .input_voltage(input_voltage),
    .exponent_code(exponent_code), .bias_ok(bias_ok),
    .output_enable(output_enable), .input_low_warning(input_low_warning),
    .input_low_fault(input_low_fault), .fault_latched(fault_latched));

  uvf_host u_host (
    .core_clk(core_clk), .reg_cmd(reg_cmd), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic wait_n(int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n

  task automatic t_regs();
    logic [15:0] d;
    u_host.rd(UVF_FAULT_ACTION_CMD, d);
    chk("action reset", 16'h0000, d);
    u_host.wr(UVF_WARN_THRESHOLD_CMD, 16'hFFFF);
    u_host.rd(UVF_WARN_THRESHOLD_CMD, d);
    chk("warn limit", 16'h2FFF, d);
    u_host.wr(UVF_FAULT_THRESHOLD_CMD, 16'h0123);
    u_host.rd(UVF_FAULT_THRESHOLD_CMD, d);
    chk("fault limit", 16'h2923, d);
    u_host.rd(8'h60, d);
    chk("unmapped", 16'h0000, d);
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h00AB);
    u_host.rd(UVF_FAULT_ACTION_CMD, d);
    chk("action", 16'h00AB, d);
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h0000);
  endtask : t_regs

  task automatic t_flags();
    u_host.wr(UVF_WARN_THRESHOLD_CMD, 16'h0200);
    u_host.wr(UVF_FAULT_THRESHOLD_CMD, 16'h0100);
    input_voltage = 11'h1FF;
    wait_n(3);
    chk("warning", 16'h1, input_low_warning);
    chk("fault", 16'h0, input_low_fault);
    input_voltage = 11'h0FF;
    wait_n(3);
    chk("fault", 16'h1, input_low_fault);
    chk("out on", 16'h1, output_enable);
    input_voltage = 11'h200;
    wait_n(3);
    chk("warning", 16'h0, input_low_warning);
  endtask : t_flags

  task automatic t_hold();
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h00C0);
    input_voltage = 11'h0FF;
    wait_n(3);
    chk("out off", 16'h0, output_enable);
    input_voltage = 11'h7FF;
    wait_n(3);
    chk("out on", 16'h1, output_enable);
  endtask : t_hold

  task automatic t_retry();
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h0088);
    input_voltage = 11'h0FF;
    wait_n(3);
    chk("out off", 16'h0, output_enable);
    wait_n(900);
    chk("still off", 16'h0, output_enable);
    input_voltage = 11'h7FF;
    wait_n(150);
    chk("restart", 16'h1, output_enable);
    chk("latched", 16'h0, fault_latched);
  endtask : t_retry

  task automatic t_latch();
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h0080);
    input_voltage = 11'h0FF;
    wait_n(5);
    chk("latched", 16'h1, fault_latched);
    input_voltage = 11'h7FF;
    wait_n(20);
    chk("latched", 16'h1, fault_latched);
    bias_ok = 1'b0;
    wait_n(4);
    bias_ok = 1'b1;
    wait_n(4);
    chk("bias clear", 16'h1, {fault_latched, output_enable});
  endtask : t_latch

  task automatic t_delay();
    logic [15:0] d;
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h0041);
    input_voltage = 11'h0FF;
    wait_n(60);
    chk("out on", 16'h1, output_enable);
    wait_n(40);
    chk("off latched", 16'h2, {fault_latched, output_enable});
    rst = 1'b1;
    wait_n(3);
    rst = 1'b0;
    wait_n(1);
    chk("rst clear", 16'h1, {fault_latched, output_enable});
    u_host.rd(UVF_FAULT_ACTION_CMD, d);
    chk("action reset", 16'h0000, d);
  endtask : t_delay

  task automatic t_forever();
    u_host.wr(UVF_FAULT_THRESHOLD_CMD, 16'h0100);
    u_host.wr(UVF_FAULT_ACTION_CMD, 16'h00B8);
    wait_n(2200);
    chk("endless", 16'h0, {fault_latched, output_enable});
    input_voltage = 11'h7FF;
    wait_n(1100);
    chk("restart", 16'h1, output_enable);
  endtask : t_forever

  initial
  begin
    rst = 1'b1;
    input_voltage = 11'h7FF;
    exponent_code = 3'h5;
    bias_ok = 1'b1;
    wait_n(10);
    rst = 1'b0;
    t_regs();
    t_flags();
    t_hold();
    t_retry();
    t_latch();
    t_delay();
    t_forever();
    stop_test();
  end
endmodule : tb_uvf_handler

`default_nettype wire

//--- test/uvf_handler_assertions.sv
`default_nettype none

module uvf_handler_assertions
  import uvf_pkg::*;
#(
  parameter int TICK_CYCLES = UVF_CLK_KHZ
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rdata,
  input wire logic [10:0] input_voltage,
  input wire logic [2:0] exponent_code,
  input wire logic bias_ok,
  input wire logic output_enable,
  input wire logic input_low_warning,
  input wire logic input_low_fault,
  input wire logic fault_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Shadow registers
  // ****
  logic [10:0] wm;
  logic [10:0] fm;
  logic [7:0] am;
  logic [1:0] rsp;
  assign rsp = am[7:6];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      {wm, fm, am} <= 30'h0;
    else if (reg_wr_en && reg_cmd == UVF_WARN_THRESHOLD_CMD)
      wm <= reg_wdata[10:0];
    else if (reg_wr_en && reg_cmd == UVF_FAULT_THRESHOLD_CMD)
      fm <= reg_wdata[10:0];
    else if (reg_wr_en && reg_cmd == UVF_FAULT_ACTION_CMD)
      am <= reg_wdata[7:0];
  end

  a_warn_flag: assert property (!$past(rst) |->
    input_low_warning == ($past(input_voltage) < $past(wm)))
    else $error("warning flag wrong");
  a_fault_flag: assert property (!$past(rst) |->
    input_low_fault == ($past(input_voltage) < $past(fm)))
    else $error("fault flag wrong");
  a_limit_read: assert property (reg_rd_en && reg_cmd[7:1] == 7'h2C
    |=> reg_rdata == {2'b00, $past(exponent_code),
    $past(reg_cmd[0] ? fm : wm)}) else $error("limit readback wrong");
  a_action_read: assert property (reg_rd_en &&
    reg_cmd == UVF_FAULT_ACTION_CMD |=> reg_rdata == {8'h00, $past(am)})
    else $error("action readback wrong");
  a_ignore_runs: assert property (rsp == UVF_RESP_IGNORE &&
    output_enable |=> output_enable) else $error("ignore code acted");
  a_delay_on: assert property (rsp == UVF_RESP_DELAYED &&
    $rose(input_low_fault) && output_enable |=> output_enable [*8])
    else $error("delayed code shut early");
  a_shut_now: assert property (rsp == UVF_RESP_RETRY &&
    input_low_fault && output_enable |=> !output_enable)
    else $error("no immediate shutdown");
  a_hold_off: assert property (rsp == UVF_RESP_HOLD &&
    input_low_fault |=> !output_enable) else $error("hold code left on");
  a_no_retry: assert property (rsp == UVF_RESP_RETRY && am[5:3] == 3'h0
    && input_low_fault && output_enable |-> ##[1:3] fault_latched)
    else $error("zero retries did not latch");
  a_latch_off: assert property (fault_latched |-> !output_enable)
    else $error("latched but output on");

  c_retry: cover property (rsp == UVF_RESP_RETRY && $fell(output_enable));
  c_latch: cover property ($rose(fault_latched));
  c_resume: cover property (rsp == UVF_RESP_HOLD && $rose(output_enable));
endmodule : uvf_handler_assertions

bind uvf_handler uvf_handler_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_cmd(reg_cmd),
  .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
  .reg_rdata(reg_rdata), .input_voltage(input_voltage),
  .exponent_code(exponent_code), .bias_ok(bias_ok),
  .output_enable(output_enable), .input_low_warning(input_low_warning),
  .input_low_fault(input_low_fault), .fault_latched(fault_latched));

`default_nettype wire

//--- test/uvf_host.sv
`default_nettype none

module uvf_host
(
  input wire logic core_clk,
  output logic [7:0] reg_cmd,
  output logic reg_wr_en,
  output logic [15:0] reg_wdata,
  output logic reg_rd_en,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Host register accesses
  // ****
  initial
  begin
    reg_cmd = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd_en = 1'b0;
  end

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    @(negedge core_clk);
    reg_cmd = cmd;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    // Stale data is inverted so nothing can lean on it.
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    @(negedge core_clk);
    reg_cmd = cmd;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : uvf_host

`default_nettype wire

//--- verilog/uvf_handler.sv
`default_nettype none

module uvf_handler
  import uvf_pkg::*;
#(
  parameter int TICK_CYCLES = UVF_CLK_KHZ
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rdata,
  input wire logic [10:0] input_voltage,
  input wire logic [2:0] exponent_code,
  input wire logic bias_ok,
  output logic output_enable,
  output logic input_low_warning,
  output logic input_low_fault,
  output logic fault_latched
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  function automatic logic below(input logic [10:0] meas,
                                 input logic [10:0] limit);
    below = meas < limit;
  endfunction : below

  function automatic logic [15:0] threshold_word(input logic [2:0] expo,
                                                 input logic [10:0] mant);
    threshold_word = {2'b00, expo, mant};
  endfunction : threshold_word

  function automatic logic [11:0] delay1_ms(input logic [2:0] code);
    delay1_ms = 12'(UVF_DELAY1_BASE_MS) << code;
  endfunction : delay1_ms

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [10:0] input_low_warning_threshold;
  logic [10:0] input_low_fault_threshold;
  logic [7:0] input_low_fault_action;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      input_low_warning_threshold <= UVF_WARN_MANT_RST;
      input_low_fault_threshold <= UVF_FAULT_MANT_RST;
      input_low_fault_action <= UVF_ACTION_RST;
    end
    else if (reg_wr_en)
    begin
      if (reg_cmd == UVF_WARN_THRESHOLD_CMD)
      begin
        input_low_warning_threshold <= reg_wdata[UVF_MANT_MSB:UVF_MANT_LSB];
      end
      else if (reg_cmd == UVF_FAULT_THRESHOLD_CMD)
      begin
        input_low_fault_threshold <= reg_wdata[UVF_MANT_MSB:UVF_MANT_LSB];
      end
      else if (reg_cmd == UVF_FAULT_ACTION_CMD)
      begin
        input_low_fault_action <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd_en)
    begin
      if (reg_cmd == UVF_WARN_THRESHOLD_CMD)
      begin
        reg_rdata <= threshold_word(exponent_code,
                                    input_low_warning_threshold);
      end
      else if (reg_cmd == UVF_FAULT_THRESHOLD_CMD)
      begin
        reg_rdata <= threshold_word(exponent_code,
                                    input_low_fault_threshold);
      end
      else if (reg_cmd == UVF_FAULT_ACTION_CMD)
      begin
        reg_rdata <= {8'h00, input_low_fault_action};
      end
      else
      begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  logic [1:0] resp;
  logic [2:0] retry_code;
  logic [2:0] delay_code;
  assign resp = input_low_fault_action[UVF_ACT_RESP_MSB:UVF_ACT_RESP_LSB];
  assign retry_code =
    input_low_fault_action[UVF_ACT_RETRY_MSB:UVF_ACT_RETRY_LSB];
  assign delay_code =
    input_low_fault_action[UVF_ACT_DELAY_MSB:UVF_ACT_DELAY_LSB];

  // ****************************************************************
  // Comparators and bias synchroniser
  // ****************************************************************

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      input_low_warning <= 1'b0;
      input_low_fault <= 1'b0;
    end
    else
    begin
      input_low_warning <= below(input_voltage,
                                 input_low_warning_threshold);
      input_low_fault <= below(input_voltage, input_low_fault_threshold);
    end
  end

  // The bias good pin is asynchronous; only the second stage is used.
  logic bias_meta;
  logic bias_sync;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bias_meta <= 1'b1;
      bias_sync <= 1'b1;
    end
    else
    begin
      bias_meta <= bias_ok;
      bias_sync <= bias_meta;
    end
  end

  // ****************************************************************
  // Response sequencer
  // ****************************************************************
  uvf_tmr_if tmr ();

  uvf_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .tmr(tmr)
  );

  uvf_state_t state;
  uvf_state_t next_state;
  logic [2:0] attempts_left;
  logic next_load_attempts;
  logic next_use_attempt;
  logic next_start;
  logic [11:0] next_ms;

  always_comb
  begin
    next_state = state;
    next_load_attempts = 1'b0;
    next_use_attempt = 1'b0;
    next_start = 1'b0;
    next_ms = 12'h000;
    case (state)
      UVF_RUN:
      begin
        if (input_low_fault)
        begin
          if (resp == UVF_RESP_DELAYED)
          begin
            next_state = UVF_DELAY;
            next_start = 1'b1;
            next_ms = delay1_ms(delay_code);
          end
          else if (resp == UVF_RESP_RETRY)
          begin
            next_load_attempts = 1'b1;
          end
          else if (resp == UVF_RESP_HOLD)
          begin
            next_state = UVF_HOLD;
          end
        end
      end
      UVF_DELAY:
      begin
        if (!input_low_fault)
        begin
          next_state = UVF_RUN;
        end
        else if (tmr.done)
        begin
          next_load_attempts = 1'b1;
        end
      end
      UVF_OFF_WAIT:
      begin
        if (tmr.done)
        begin
          if (!input_low_fault)
          begin
            next_state = UVF_RUN;
          end
          else if (retry_code == UVF_RETRY_FOREVER || attempts_left > 3'h1)
          begin
            next_use_attempt = 1'b1;
            next_start = 1'b1;
            next_ms = UVF_DELAY2_MS[delay_code];
          end
          else
          begin
            next_state = UVF_LATCHED;
          end
        end
      end
      UVF_HOLD:
      begin
        if (!input_low_fault)
        begin
          next_state = UVF_RUN;
        end
      end
      UVF_LATCHED:
      begin
        next_state = UVF_LATCHED;
      end
      default:
      begin
        next_state = UVF_RUN;
      end
    endcase
    // A shutdown waits out delay two, or latches when no retry is allowed.
    if (next_load_attempts)
    begin
      next_state = UVF_LATCHED;
      if (retry_code != 3'h0)
      begin
        next_state = UVF_OFF_WAIT;
        next_start = 1'b1;
        next_ms = UVF_DELAY2_MS[delay_code];
      end
    end
  end

  assign tmr.start = next_start;
  assign tmr.ms = next_ms;

  always_ff @(posedge core_clk)
  begin
    if (rst || !bias_sync)
    begin
      state <= UVF_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      attempts_left <= 3'h0;
    end
    else if (next_load_attempts)
    begin
      attempts_left <= retry_code;
    end
    else if (next_use_attempt && retry_code != UVF_RETRY_FOREVER)
    begin
      attempts_left <= attempts_left - 3'h1;
    end
  end

  // The output follows the next state so it drops the edge after the cause.
  always_ff @(posedge core_clk)
  begin
    if (rst || !bias_sync)
    begin
      output_enable <= 1'b1;
      fault_latched <= 1'b0;
    end
    else
    begin
      output_enable <= (next_state == UVF_RUN) || (next_state == UVF_DELAY);
      fault_latched <= next_state == UVF_LATCHED;
    end
  end

endmodule : uvf_handler

`default_nettype wire

//--- verilog/uvf_ms_timer.sv
`default_nettype none

module uvf_ms_timer
  import uvf_pkg::*;
#(
  parameter int TICK_CYCLES = UVF_CLK_KHZ
)
(
  input wire logic core_clk,
  input wire logic rst,
  uvf_tmr_if.tmr tmr
);

  logic running;
  logic [11:0] ms_left;
  logic [31:0] presc;
  logic done_q;

  // A new start always reloads, so a stale countdown never leaks through.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      running <= 1'b0;
      ms_left <= 12'h000;
      presc <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else if (tmr.start)
    begin
      running <= 1'b1;
      ms_left <= tmr.ms;
      presc <= 32'h0000_0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (running)
      begin
        if (presc == 32'(TICK_CYCLES - 1))
        begin
          presc <= 32'h0000_0000;
          if (ms_left <= 12'h001)
          begin
            running <= 1'b0;
            done_q <= 1'b1;
          end
          else
          begin
            ms_left <= ms_left - 12'h001;
          end
        end
        else
        begin
          presc <= presc + 32'h0000_0001;
        end
      end
    end
  end

  assign tmr.done = done_q;

endmodule : uvf_ms_timer

`default_nettype wire
